// >>> src/udh_extract.sv
// module: user-defined hash byte extraction and hash for path selection
`timescale 1ns/1ps
`default_nettype none
module udh_extract
  import udh_pkg::*;
#(
  parameter int NP = NUM_PROF
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // this line card and per-profile settings, packed by profile index
  input wire logic [CARD_W-1:0] MY_CARD,
  input wire logic [NP-1:0] PROF_EN,
  input wire logic [NP*CARD_W-1:0] PROF_CARD,
  input wire logic [NP*OFS_W-1:0] PROF_OFS,
  input wire logic [NP*SIZE_W-1:0] PROF_SIZE,
  // packet descriptor from parser, valid with PKT_SOP
  input wire logic PKT_SOP,
  input wire logic PKT_IS_V6,
  input wire logic [7:0] PKT_PROTO,
  input wire logic [127:0] PKT_SRC_IP,
  input wire logic [127:0] PKT_DST_IP,
  input wire logic [19:0] PKT_FLOW_LABEL,
  input wire logic [15:0] PKT_SRC_PORT,
  input wire logic [15:0] PKT_DST_PORT,
  input wire logic [15:0] PKT_IN_IF,
  input wire logic [15:0] PKT_ROUTER_ID,
  // packet byte stream from parser, counted from start of ip header
  input wire logic PKT_BYTE_VLD,
  input wire logic [7:0] PKT_BYTE,
  input wire logic PKT_EOP,
  // hash result towards path and member selection
  output logic [31:0] HASH_OUT,
  output logic HASH_VLD,
  output logic [3:0] USER_LEN,
  output logic [31:0] USER_BYTES
);

  ////////////////////////////////////////////////////////////////////////
  // profile decode
  logic [2:0] prof_idx; // selected profile number
  logic [NP-1:0] prof_hit; // profile enabled here
  logic [15:0] hdr_len; // basic header length, no options

  // profile number is 3*v6 plus 0 tcp, 1 udp, 2 other
  // header length counts only the basic ip and transport header,
  // so option bytes are treated as payload by the offset
  // profile index from ip version and leading transport
  always_comb begin
    prof_idx = PKT_IS_V6 ? 3'h3 : 3'h0;
    if (PKT_PROTO == PROTO_TCP) begin
      hdr_len = (PKT_IS_V6 ? IP6_BASE_LEN : IP4_BASE_LEN) + TCP_BASE_LEN;
    end else if (PKT_PROTO == PROTO_UDP) begin
      prof_idx = prof_idx + 3'h1;
      hdr_len = (PKT_IS_V6 ? IP6_BASE_LEN : IP4_BASE_LEN) + UDP_LEN;
    end else begin
      prof_idx = prof_idx + 3'h2;
      hdr_len = PKT_IS_V6 ? IP6_BASE_LEN : IP4_BASE_LEN;
    end
  end

  // a profile set up for another card is simply never hit
  // per-profile enable gated by line card match
  genvar g;
  generate
    for (g = 0; g < NP; g++) begin : g_prof
      assign prof_hit[g] = PROF_EN[g] && (PROF_CARD[g*CARD_W +: CARD_W] == MY_CARD);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // packet state
  state_t state_r;
  logic [15:0] pos_r; // byte position in packet
  logic [15:0] start_r; // first user byte position
  logic [2:0] size_r; // bytes to take, 0 when no profile
  logic [31:0] ubytes_r; // captured user bytes, zero filled
  logic [31:0] fixed_r; // hash of fixed fields
  logic [31:0] hash_r;
  logic hvld_r;

  // multiply after xor spreads each input bit only into the bits above it
  // fold of fixed fields, ipv6 adds flow label
  function automatic logic [31:0] mix(input logic [31:0] h, input logic [31:0] d);
    mix = (h ^ d) * HASH_MUL;
  endfunction

  logic [31:0] fixed_h; // fixed hash of current descriptor
  always_comb begin
    fixed_h = HASH_SEED;
    for (int i = 0; i < 4; i++) begin
      fixed_h = mix(fixed_h, PKT_SRC_IP[i*32 +: 32]);
      fixed_h = mix(fixed_h, PKT_DST_IP[i*32 +: 32]);
    end
    fixed_h = mix(fixed_h, {8'h00, PKT_PROTO, PKT_ROUTER_ID});
    fixed_h = mix(fixed_h, {PKT_SRC_PORT, PKT_DST_PORT});
    fixed_h = mix(fixed_h, {16'h0000, PKT_IN_IF});
    if (PKT_IS_V6) begin
      fixed_h = mix(fixed_h, {12'h000, PKT_FLOW_LABEL});
    end
  end

  // user size of selected profile, zero when profile not hit or size outside legal range
  logic [2:0] sel_size;
  always_comb begin
    sel_size = PROF_SIZE[prof_idx*SIZE_W +: SIZE_W];
    if (!prof_hit[prof_idx] || sel_size < SIZE_MIN || sel_size > SIZE_MAX) begin
      sel_size = 3'h0;
    end
  end

  // idle waits for sop, body takes bytes until eop, hash lasts one cycle
  // a sop seen in body or hash is dropped without notice
  // packet sequencing
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      state_r <= ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (PKT_SOP) begin
            state_r <= PKT_EOP ? ST_HASH : ST_BODY;
          end
        end
        ST_BODY: begin
          if (PKT_EOP) begin
            state_r <= ST_HASH;
          end
        end
        ST_HASH: begin
          state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // descriptor capture at start of packet
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      start_r <= 16'h0000;
      size_r <= 3'h0;
      fixed_r <= 32'h00000000;
    end else if (state_r == ST_IDLE && PKT_SOP) begin
      start_r <= hdr_len + {8'h00, PROF_OFS[prof_idx*OFS_W +: OFS_W]};
      size_r <= sel_size;
      fixed_r <= fixed_h;
    end
  end

  // positions count from the first ip header byte, which may ride on sop
  // byte position counter, starts at the sop byte
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      pos_r <= 16'h0000;
    end else if (state_r == ST_IDLE && PKT_SOP) begin
      pos_r <= PKT_BYTE_VLD ? 16'h0001 : 16'h0000;
    end else if (state_r == ST_BODY && PKT_BYTE_VLD) begin
      pos_r <= pos_r + 16'h0001;
    end
  end

  // the sop cycle reads the live descriptor, later cycles the copy in
  // start_r and size_r, so a settings change mid-packet is harmless
  // user byte capture; missing bytes stay zero
  logic [15:0] cur_pos; // position of byte on the bus now
  logic [15:0] rel; // distance from start of user bytes
  assign cur_pos = (state_r == ST_IDLE) ? 16'h0000 : pos_r;
  assign rel = cur_pos - ((state_r == ST_IDLE) ? hdr_len + {8'h00, PROF_OFS[prof_idx*OFS_W +: OFS_W]} : start_r);
  logic [2:0] cur_size;
  assign cur_size = (state_r == ST_IDLE) ? sel_size : size_r;

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ubytes_r <= 32'h00000000;
    end else if (state_r == ST_IDLE && PKT_SOP) begin
      ubytes_r <= 32'h00000000;
      if (PKT_BYTE_VLD && rel < {13'h0000, cur_size}) begin
        ubytes_r[rel[1:0]*8 +: 8] <= PKT_BYTE;
      end
    end else if (state_r == ST_BODY && PKT_BYTE_VLD && cur_pos >= start_r && rel < {13'h0000, cur_size}) begin
      ubytes_r[rel[1:0]*8 +: 8] <= PKT_BYTE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // hash and user outputs change together with the valid pulse
  // and then hold until the next packet's result
  // hash result, one per packet
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      hash_r <= 32'h00000000;
      hvld_r <= 1'b0;
    end else begin
      hvld_r <= (state_r == ST_HASH);
      if (state_r == ST_HASH) begin
        // user bytes join, never replace, the fixed fields
        hash_r <= (size_r != 3'h0) ? mix(fixed_r, ubytes_r) : fixed_r;
      end
    end
  end

  // user length is zero when no profile matched, user bytes then zero
  // registered outputs
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      USER_LEN <= 4'h0;
      USER_BYTES <= 32'h00000000;
    end else if (state_r == ST_HASH) begin
      USER_LEN <= {1'b0, size_r};
      USER_BYTES <= ubytes_r;
    end
  end

  assign HASH_OUT = hash_r;
  assign HASH_VLD = hvld_r;

endmodule // udh_extract
`default_nettype wire

// >>> src/udh_pkg.sv
// package: constants and types for user-defined hash byte extraction
// Function
// - six independently enabled extraction profiles
// - user bytes added to fixed hash fields
// - offset counted from named header end
// - size one to four consecutive bytes
// - offset zero is first payload byte
// - settings apply only to own line card
// - header options ignored when locating bytes
// - hash drives path and member selection
// - only leading IP and transport header matched
// - fixed fields: addresses, protocol, ports, ids
package udh_pkg;
  localparam int NUM_PROF = 6; // ipv4/ipv6 x tcp/udp/other
  localparam int OFS_W = 8; // offset field width
  localparam int SIZE_W = 3; // size field width
  localparam int CARD_W = 4; // line card id width
  localparam logic [2:0] SIZE_MIN = 3'h1; // least extraction size
  localparam logic [2:0] SIZE_MAX = 3'h4; // largest extraction size
  localparam logic [7:0] PROTO_TCP = 8'h06; // ip protocol tcp
  localparam logic [7:0] PROTO_UDP = 8'h11; // ip protocol udp
  localparam logic [15:0] IP4_BASE_LEN = 16'h0014; // basic ipv4 header bytes
  localparam logic [15:0] IP6_BASE_LEN = 16'h0028; // basic ipv6 header bytes
  localparam logic [15:0] TCP_BASE_LEN = 16'h0014; // basic tcp header bytes
  localparam logic [15:0] UDP_LEN = 16'h0008; // udp header bytes
  localparam logic [31:0] HASH_SEED = 32'h811C9DC5; // mixing seed
  localparam logic [31:0] HASH_MUL = 32'h01000193; // mixing multiplier
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BODY = 2'b01,
    ST_HASH = 2'b10
  } state_t;
endpackage

// >>> verif/udh_chk_sva.sv
// checker: output timing of the hash result
`timescale 1ns/1ps
`default_nettype none
module udh_chk
  import udh_pkg::*;
#(
  parameter int NP = NUM_PROF
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // watched ports
  input wire logic PKT_EOP,
  input wire logic [31:0] HASH_OUT,
  input wire logic HASH_VLD,
  input wire logic [3:0] USER_LEN,
  input wire logic [31:0] USER_BYTES
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  a_vld_after_eop: assert property (PKT_EOP |-> ##2 HASH_VLD) else $error("no result after eop");
  a_vld_has_cause: assert property (HASH_VLD |-> $past(PKT_EOP, 2)) else $error("result without eop");
  a_vld_one_cycle: assert property (HASH_VLD |=> !HASH_VLD) else $error("valid too long");
  a_hash_holds: assert property (!HASH_VLD |-> $stable(HASH_OUT)) else $error("hash moved");
  a_user_holds: assert property (!HASH_VLD |-> $stable(USER_BYTES) && $stable(USER_LEN)) else $error("user moved");
  a_len_range: assert property (USER_LEN <= 4'h4) else $error("size out of range");
  a_upper_zero: assert property ((USER_BYTES >> (8 * USER_LEN)) == 32'h0) else $error("stray byte");
  a_reset_clear: assert property (disable iff (1'b0) RST |=>
    !HASH_VLD && HASH_OUT == 32'h0 && USER_LEN == 4'h0) else $error("reset left output");
endmodule // udh_chk
bind udh_extract udh_chk #(.NP(NP)) i_chk (.CLOCK(CLOCK), .RST(RST), .PKT_EOP(PKT_EOP), .HASH_OUT(HASH_OUT),
  .HASH_VLD(HASH_VLD), .USER_LEN(USER_LEN), .USER_BYTES(USER_BYTES));
`default_nettype wire

// >>> verif/pkt_src.sv
// parser model: streams one packet a byte a cycle
`timescale 1ns/1ps
`default_nettype none
module pkt_src (
  // clock
  input wire logic clk,
  // byte stream
  output logic sop,
  output logic vld,
  output logic [7:0] bo,
  output logic eop
);
  logic [7:0] mem [0:127]; // bytes from ip header on
  initial begin
    {sop, vld, eop, bo} = 11'h0;
  end
  // sop with byte 0, eop with last byte
  task automatic send(input int len);
    for (int i = 0; i < len; i++) begin
      @(posedge clk);
      #1;
      {sop, vld, eop} = {i == 0, 1'b1, i == len - 1};
      bo = mem[i];
    end
    @(posedge clk);
    #1;
    {sop, vld, eop} = 3'h0;
    bo = ~bo; // released line shows no stale byte
  endtask
endmodule // pkt_src
`default_nettype wire

// >>> verif/tb_top.sv
// bench: random profiles and packets, user bytes checked
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin miscompares++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
  import udh_pkg::*;
  logic CLOCK = 1'b0;
  logic RST = 1'b1;
  logic [5:0] en = 6'h0;
  logic [23:0] card = 24'h0;
  logic [47:0] ofs = 48'h0;
  logic [17:0] size = 18'h0;
  logic v6 = 1'b0;
  logic [7:0] proto = 8'h0;
  logic [127:0] ip = 128'h0;
  logic [127:0] dip = 128'h0; // destination address, v4 upper bits zero
  logic [3:0] me = 4'h3; // this line card, random per packet
  logic [15:0] w = 16'h0;
  logic sop, vld, eop, hv;
  logic [7:0] bo;
  logic [31:0] ho, ub, e, h;
  logic [3:0] ul;
  logic [67:0] q[$], x; // {user_len, user_bytes, hash}
  int seed = 10950;
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;
  int p, t, hl, len, o, s;
  initial forever #5 CLOCK = ~CLOCK;
  pkt_src i_src (.clk(CLOCK), .sop(sop), .vld(vld), .bo(bo), .eop(eop));
  udh_extract i_dut (.CLOCK(CLOCK), .RST(RST), .MY_CARD(me), .PROF_EN(en), .PROF_CARD(card), .PROF_OFS(ofs),
    .PROF_SIZE(size), .PKT_SOP(sop), .PKT_IS_V6(v6), .PKT_PROTO(proto), .PKT_SRC_IP(ip), .PKT_DST_IP(dip),
    .PKT_FLOW_LABEL(ip[19:0]), .PKT_SRC_PORT(w), .PKT_DST_PORT(~w), .PKT_IN_IF(w), .PKT_ROUTER_ID(ip[15:0]),
    .PKT_BYTE_VLD(vld), .PKT_BYTE(bo), .PKT_EOP(eop), .HASH_OUT(ho), .HASH_VLD(hv), .USER_LEN(ul), .USER_BYTES(ub));
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // reference fold of one word into the running hash
  function automatic logic [31:0] fnv(input logic [31:0] a0, input logic [31:0] d);
    fnv = (a0 ^ d) * HASH_MUL;
  endfunction
  // watch results, compare with oldest note
  always @(posedge CLOCK) begin
    cycles++;
    if (cycles > 20000) begin
      miscompares++;
      final_report();
    end else if (hv === 1'b1) begin
      x = (q.size() > 0) ? q.pop_front() : {68{1'b1}};
      `CHK(ul, x[67:64])
      `CHK(ub, x[63:32])
      `CHK(ho, x[31:0])
    end
  end
  // every profile in turn, random settings and packets
  initial begin
    repeat (4) @(posedge CLOCK);
    #1 RST = 1'b0;
    for (int n = 0; n < 72; n++) begin
      p = n % 6;
      t = p % 3;
      me = 4'($random(seed));
      {en, size} = 24'($random(seed));
      {ofs, card} = 72'({$random(seed), $random(seed), $random(seed)});
      o = $unsigned($random(seed)) % 8;
      ofs[8*p+:8] = o[7:0];
      card[4*p+:4] = (n % 4 == 3) ? ~me : me;
      s = int'(size[3*p+:3]);
      v6 = p >= 3;
      proto = (t == 0) ? PROTO_TCP : (t == 1) ? PROTO_UDP : 8'h3B;
      {ip, w} = 144'({$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)});
      if (!v6) ip[127:32] = 96'h0;
      dip = ~ip;
      if (!v6) dip[127:32] = 96'h0;
      hl = (v6 ? 40 : 20) + ((t == 0) ? 20 : (t == 1) ? 8 : 0);
      len = hl + $unsigned($random(seed)) % 14;
      for (int i = 0; i < len; i++) i_src.mem[i] = 8'($random(seed));
      e = 32'h0;
      if (!(en[p] && card[4*p+:4] == me && s >= 1 && s <= 4)) s = 0;
      for (int k = 0; k < s; k++) if (hl + o + k < len) e[8*k+:8] = i_src.mem[hl+o+k];
      // expected hash: fixed fields first, user bytes folded on top
      h = HASH_SEED;
      for (int i = 0; i < 4; i++) h = fnv(fnv(h, ip[32*i+:32]), dip[32*i+:32]);
      h = fnv(h, {8'h00, proto, ip[15:0]});
      h = fnv(h, {w, ~w});
      h = fnv(h, {16'h0000, w});
      if (v6) h = fnv(h, {12'h000, ip[19:0]});
      if (s != 0) h = fnv(h, e);
      q.push_back({s[3:0], e, h});
      i_src.send(len);
      repeat (2) @(posedge CLOCK);
      #1;
    end
    repeat (4) @(posedge CLOCK);
    `CHK(q.size(), 0)
    final_report();
  end
endmodule // tb_top
`default_nettype wire
